// File: bomt_defs.vh
`ifndef BOMT_DEFS_VH
`define BOMT_DEFS_VH
// ****************************************
// register offsets
// ****************************************
`define BOMT_ADDR_CTRL     8'h0_0A0
`define BOMT_ADDR_TXCW     8'h0_0A1
`define BOMT_ADDR_RXCW     8'h0_0A2
`define BOMT_ADDR_STAT     8'h0_0A3
// ****************************************
// control field positions and values
// ****************************************
`define BOMT_CTRL_RST      8'h0_000
`define BOMT_RX_EN_BIT     7
`define BOMT_RX_INTEG_BIT  6
`define BOMT_LEN_1         2'h0
`define BOMT_LEN_10        2'h1
`define BOMT_LEN_25        2'h2
`define BOMT_LEN_CONT      2'h3
`define BOMT_CNT_1         5'h0_001
`define BOMT_CNT_10        5'h0_00A
`define BOMT_CNT_25        5'h0_019
// ****************************************
// pattern layout
// ****************************************
`define BOMT_FLAG_BYTE     8'h0_0FF
`define BOMT_PAT_BITS      5'h0_010
`define BOMT_ABORT_BITS    4'h8
`endif

// File: bomt_transceiver.v
// Decided for this implementation: the strobed register port.
`include "bomt_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module bomt_transceiver (
  // clock and reset
  input  wire       clock,
  input  wire       srst,
  // register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_q,
  // link bit timing, one pulse per data link bit
  input  wire       tx_bit_tick,
  input  wire       rx_bit_tick,
  input  wire       rx_bit,
  // first data link controller
  input  wire       dl_tx_bit,
  input  wire       dl_buf_empty,
  input  wire       dl_out_idle,
  input  wire       prm_pending,
  // outputs
  output reg        tx_bit_q,
  output reg        dl_suspend_q,
  output reg        tx_msg_irq_q,
  output reg        rx_msg_irq_q
);
  // ****************************************
  // registers
  // ****************************************
  reg [7:0] ctrl_q;
  reg [5:0] txcw_q;
  reg [5:0] rxcw_q;
  reg       valid_q;
  reg       lost_q;
  wire [1:0] tx_len  = ctrl_q[3:2];
  wire [1:0] tx_mode = ctrl_q[1:0];
  wire [1:0] rx_len  = ctrl_q[5:4];
  wire       rx_en   = ctrl_q[`BOMT_RX_EN_BIT];
  wire       integ   = ctrl_q[`BOMT_RX_INTEG_BIT];
  wire       tx_on   = tx_mode[1];
  wire       wr_tx   = reg_wr && reg_addr == `BOMT_ADDR_TXCW && tx_on;

  // length field to pattern count
  function [4:0] len_cnt;
    input [1:0] len;
    begin
      case (len)
        `BOMT_LEN_10: len_cnt = `BOMT_CNT_10;
        `BOMT_LEN_25: len_cnt = `BOMT_CNT_25;
        `BOMT_LEN_1:  len_cnt = `BOMT_CNT_1;
        // continuous mode has no count of its own
        default:      len_cnt = `BOMT_CNT_1;
      endcase
    end
  endfunction

  // ****************************************
  // transmitter
  // ****************************************
  localparam TX_IDLE  = 2'd0;
  localparam TX_ABORT = 2'd1;
  localparam TX_SEND  = 2'd2;
  reg [1:0]  tx_st_q;
  reg [15:0] tx_sh_q;
  reg [4:0]  tx_bit_cnt_q;
  reg [4:0]  tx_pat_cnt_q;
  reg [3:0]  abort_cnt_q;
  reg        pend_q;
  reg [5:0]  pend_cw_q;
  wire [15:0] pattern = {1'b0, pend_cw_q, 1'b0, `BOMT_FLAG_BYTE};
  reg  dl_busy;
  reg  may_go;
  reg  pat_end;
  reg  yield;
  // active from the write until the last pattern has left
  wire tx_active = tx_st_q != TX_IDLE || pend_q;

  // arbitration against report traffic and the link buffer
  always @* begin
    dl_busy = !dl_buf_empty || !dl_out_idle;
    may_go  = 1'b0;
    yield   = 1'b0;
    pat_end = 1'b0;
    if (prm_pending) begin
      // report messages always go first
      may_go = 1'b0;
      yield  = 1'b1;
    end else if (tx_mode[0]) begin
      // buffer priority: wait for an empty, idle buffer
      may_go = !dl_busy;
      yield  = dl_busy;
    end else begin
      // message priority: go now, the buffer output is cut short
      may_go = 1'b1;
    end
    if (tx_bit_tick && tx_bit_cnt_q == `BOMT_PAT_BITS - 5'd1)
      pat_end = 1'b1;
  end

  // channel output: message bits while sending, else the buffer's bit
  always @(posedge clock) begin
    if (srst) begin
      tx_bit_q <= 1'b1;
    end else if (tx_bit_tick) begin
      if (tx_st_q == TX_SEND)
        tx_bit_q <= tx_sh_q[0];
      else
        tx_bit_q <= dl_tx_bit;
    end
  end

  // message sequencer; the new codeword waits in pend until it can start
  always @(posedge clock) begin
    if (srst) begin
      tx_st_q      <= TX_IDLE;
      tx_sh_q      <= 16'h0_000;
      tx_bit_cnt_q <= 5'h0_000;
      tx_pat_cnt_q <= 5'h0_000;
      abort_cnt_q  <= 4'h0;
      pend_q       <= 1'b0;
      pend_cw_q    <= 6'h0_000;
      txcw_q       <= 6'h0_000;
      tx_msg_irq_q <= 1'b0;
      dl_suspend_q <= 1'b0;
    end else begin
      tx_msg_irq_q <= 1'b0;
      if (wr_tx) begin
        pend_q    <= 1'b1;
        pend_cw_q <= reg_wdata[5:0];
        txcw_q    <= reg_wdata[5:0];
      end
      // a message left pending when the transmitter is turned off is dropped
      if (!tx_on)
        pend_q <= 1'b0;
      case (tx_st_q)
        TX_IDLE: begin
          dl_suspend_q <= 1'b0;
          if (pend_q && !wr_tx && may_go && tx_on) begin
            // message priority cuts buffer output short, limited to 8 bits
            tx_st_q      <= tx_mode[0] ? TX_SEND : TX_ABORT;
            dl_suspend_q <= 1'b1;
            abort_cnt_q  <= 4'h0;
            tx_sh_q      <= pattern;
            tx_bit_cnt_q <= 5'h0_000;
            tx_pat_cnt_q <= 5'h0_000;
            pend_q       <= 1'b0;
            tx_msg_irq_q <= 1'b1;
          end
        end
        TX_ABORT: begin
          // give the buffer framer a short grace, then send
          if (tx_bit_tick) begin
            abort_cnt_q <= abort_cnt_q + 4'h1;
            if (dl_out_idle || abort_cnt_q == `BOMT_ABORT_BITS - 4'h1)
              tx_st_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_bit_tick) begin
            tx_sh_q      <= {tx_sh_q[0], tx_sh_q[15:1]};
            tx_bit_cnt_q <= tx_bit_cnt_q + 5'h0_001;
          end
          if (pat_end) begin
            tx_bit_cnt_q <= 5'h0_000;
            tx_pat_cnt_q <= tx_pat_cnt_q + 5'h0_001;
            if (tx_len == `BOMT_LEN_CONT) begin
              if (yield) begin
                tx_st_q <= TX_IDLE;
                pend_q  <= 1'b1;    // resume after the other traffic
              end
            end else if (tx_pat_cnt_q + 5'h0_001 >= len_cnt(tx_len))
              tx_st_q <= TX_IDLE;
          end
          if (!tx_on)
            tx_st_q <= TX_IDLE;
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  reg [15:0] rx_sh_q;
  reg [4:0]  rx_gap_q;     // bits since last pattern end, saturating
  reg [5:0]  last_cw_q;
  reg        have_last_q;
  reg [4:0]  run_q;
  reg        rx_active_q;
  wire [15:0] rx_win = {rx_bit, rx_sh_q[15:1]};
  wire        hit    = rx_bit_tick && rx_en &&
                       rx_win[7:0] == `BOMT_FLAG_BYTE && !rx_win[8] && !rx_win[15];
  wire [5:0]  cw     = rx_win[14:9];
  wire        same   = have_last_q && cw == last_cw_q;
  // integration: only back-to-back identical patterns count
  wire        adj    = rx_gap_q == `BOMT_PAT_BITS - 5'd1;
  wire        counts = !integ || (same && adj);
  wire [4:0]  need   = len_cnt(rx_len);
  reg  [4:0]  run_n;
  reg         qual;

  // next run length and qualification for the pattern now completing
  always @* begin
    run_n = 5'h0_000;
    qual  = 1'b0;
    if (same) begin
      // identical pattern extends the run; gapped ones stall under integration
      run_n = run_q + {4'h0, counts};
    end else begin
      // a different codeword starts a fresh run
      run_n = {4'h0, !integ};
    end
    if (hit) begin
      case (rx_len)
        `BOMT_LEN_CONT: begin
          // change mode: every new codeword qualifies at once
          qual = !same;
        end
        default: begin
          // count modes fire once, when the run first reaches the target
          if (run_n == need && !(same && run_q >= need))
            qual = 1'b1;
        end
      endcase
    end
  end
  wire        rd_rx  = reg_rd && reg_addr == `BOMT_ADDR_RXCW;

  // pattern search and qualification
  always @(posedge clock) begin
    if (srst) begin
      rx_sh_q      <= 16'h0_000;
      rx_gap_q     <= 5'h0_000;
      last_cw_q    <= 6'h0_000;
      have_last_q  <= 1'b0;
      run_q        <= 5'h0_000;
      rx_active_q  <= 1'b0;
      rxcw_q       <= 6'h0_000;
      valid_q      <= 1'b0;
      lost_q       <= 1'b0;
      rx_msg_irq_q <= 1'b0;
    end else begin
      rx_msg_irq_q <= 1'b0;
      if (rd_rx)
        valid_q <= 1'b0;
      if (!rx_en) begin
        have_last_q <= 1'b0;
        run_q       <= 5'h0_000;
        rx_active_q <= 1'b0;
      end else if (rx_bit_tick) begin
        rx_sh_q <= rx_win;
        if (rx_gap_q != 5'h1_F)
          rx_gap_q <= rx_gap_q + 5'h0_001;
        if (hit) begin
          rx_gap_q    <= 5'h0_000;
          last_cw_q   <= cw;
          have_last_q <= 1'b1;
          run_q       <= run_n;
          rx_active_q <= !qual && need != `BOMT_CNT_1;
          if (qual) begin
            rxcw_q       <= cw;
            rx_msg_irq_q <= 1'b1;
            valid_q      <= 1'b1;         // set wins over read
            if (valid_q && !rd_rx)
              lost_q <= 1'b1;
          end
        end
      end
      // a read reports the flag, so it always clears it
      if (rd_rx)
        lost_q <= 1'b0;
    end
  end

  // ****************************************
  // register port
  // ****************************************
  reg  [7:0] rd_mux;
  wire       wr_ctrl = reg_wr && reg_addr == `BOMT_ADDR_CTRL;

  // control register; codeword and status offsets are not writable here
  always @(posedge clock) begin
    if (srst) begin
      ctrl_q <= `BOMT_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata;
    end
  end

  // read selection; unmapped offsets read as zero
  always @* begin
    rd_mux = 8'h0_000;
    case (reg_addr)
      `BOMT_ADDR_CTRL: rd_mux = ctrl_q;
      `BOMT_ADDR_TXCW: rd_mux = {2'b00, txcw_q};
      `BOMT_ADDR_RXCW: rd_mux = {lost_q, valid_q, rxcw_q};
      `BOMT_ADDR_STAT: rd_mux = {tx_active, rx_active_q, 6'h0_000};
      default:         rd_mux = 8'h0_000;
    endcase
  end

  // read data stand for one cycle only, then return to zero
  always @(posedge clock) begin
    if (srst) begin
      reg_rdata_q <= 8'h0_000;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= 8'h0_000;
    end
  end
endmodule
`default_nettype wire

// File: bomt_transceiver_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// protocol checker
// ****
module bomt_chk (
  // clock and reset
  input wire logic       clock,
  input wire logic       srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  // link side
  input wire logic       tx_bit_tick,
  input wire logic       dl_tx_bit,
  input wire logic       prm_pending,
  input wire logic       tx_bit_q,
  input wire logic       dl_suspend_q,
  input wire logic       tx_msg_irq_q,
  input wire logic       rx_msg_irq_q
);
  logic [7:0] ctl_q;
  logic [9:0] cnt_q;
  // control shadow; tick in the start cycle already counts
  always_ff @(posedge clock) begin
    if (srst) begin
      ctl_q <= 8'h00;
      cnt_q <= 10'h000;
    end else begin
      if (reg_wr && reg_addr == 8'hA0)
        ctl_q <= reg_wdata;
      if (tx_msg_irq_q)
        cnt_q <= {9'h000, tx_bit_tick};
      else if (tx_bit_tick && dl_suspend_q)
        cnt_q <= cnt_q + 10'h001;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  AST_TX_IRQ_PULSE: assert property (tx_msg_irq_q |=> !tx_msg_irq_q)
    else $error("tx irq too long");
  AST_RX_IRQ_PULSE: assert property (rx_msg_irq_q |=> !rx_msg_irq_q)
    else $error("rx irq too long");
  AST_START_SUSPENDS: assert property (tx_msg_irq_q |-> dl_suspend_q)
    else $error("start without suspend");
  AST_SUSPEND_CAUSE: assert property ($rose(dl_suspend_q) |-> tx_msg_irq_q)
    else $error("suspend without start");
  AST_TX_HOLD: assert property (!tx_bit_tick |=> $stable(tx_bit_q))
    else $error("tx bit moved off tick");
  AST_PASS_THRU: assert property (tx_bit_tick && !dl_suspend_q ##1 !dl_suspend_q
    |-> tx_bit_q == $past(dl_tx_bit))
    else $error("buffer bit not passed");
  AST_RX_OFF: assert property (!ctl_q[7] && !$past(ctl_q[7]) |-> !rx_msg_irq_q)
    else $error("rx irq while off");
  AST_TX_OFF: assert property (tx_msg_irq_q |-> $past(ctl_q[1]))
    else $error("tx start while disabled");
  AST_PRM_FIRST: assert property (prm_pending && !dl_suspend_q |=> !tx_msg_irq_q)
    else $error("start over report");
  AST_MSG_LEN: assert property ($fell(dl_suspend_q) |-> cnt_q >= 10'd16)
    else $error("message shorter than a pattern");
  cover property (rx_msg_irq_q);
  cover property (tx_msg_irq_q);
  cover property ($fell(dl_suspend_q));
endmodule
bind bomt_transceiver bomt_chk chk (.clock(clock), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .tx_bit_tick(tx_bit_tick),
  .dl_tx_bit(dl_tx_bit), .prm_pending(prm_pending), .tx_bit_q(tx_bit_q),
  .dl_suspend_q(dl_suspend_q), .tx_msg_irq_q(tx_msg_irq_q), .rx_msg_irq_q(rx_msg_irq_q));
`default_nettype wire

// File: bomt_far.sv
`timescale 1ns/10ps
`default_nettype none
// far line end: sends codeword patterns, one bit per four clocks
module bomt_far (
  // clock
  input  wire logic clock,
  // receive link
  output var  logic rx_bit,
  output var  logic rx_bit_tick
);
  initial begin
    rx_bit = 1'b0;
    rx_bit_tick = 1'b0;
  end
  // line inverted between ticks so a stale bit never looks valid
  task automatic send(input logic [5:0] cw, input int n);
    logic [15:0] pat;
    pat = {1'b0, cw, 1'b0, 8'hFF};
    repeat (n) begin
      for (int i = 0; i < 16; i++) begin
        @(posedge clock);
        rx_bit <= pat[i];
        rx_bit_tick <= 1'b1;
        @(posedge clock);
        rx_bit_tick <= 1'b0;
        rx_bit <= ~pat[i];
        repeat (2) @(posedge clock);
      end
    end
  endtask
endmodule
`default_nettype wire

// File: bomt_transceiver_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bomt_transceiver_tb;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        tx_bit_tick = 1'b0;
  logic        dl_tx_bit = 1'b0;
  logic        dl_buf_empty = 1'b1;
  logic        dl_out_idle = 1'b1;
  logic        prm_pending = 1'b0;
  logic        cap_en = 1'b0;
  logic [1:0]  tdiv = 2'd0;
  logic [15:0] shift = 16'h0000;
  wire  [7:0]  reg_rdata_q;
  wire         rx_bit, rx_bit_tick, tx_bit_q, dl_suspend_q, tx_msg_irq_q, rx_msg_irq_q;
  int fail_count = 0;
  int total_checks = 0;
  int rx_irqs = 0;
  int tx_irqs = 0;
  int nbits = 0;
  int cycles = 0;
  int base;
  bomt_transceiver uut (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .tx_bit_tick(tx_bit_tick), .rx_bit_tick(rx_bit_tick), .rx_bit(rx_bit),
    .dl_tx_bit(dl_tx_bit), .dl_buf_empty(dl_buf_empty), .dl_out_idle(dl_out_idle),
    .prm_pending(prm_pending), .tx_bit_q(tx_bit_q), .dl_suspend_q(dl_suspend_q),
    .tx_msg_irq_q(tx_msg_irq_q), .rx_msg_irq_q(rx_msg_irq_q));
  bomt_far far (.clock(clock), .rx_bit(rx_bit), .rx_bit_tick(rx_bit_tick));
  always #10 clock = ~clock;
  // tx ticks, toggling buffer bits, capture of message bits, event counts
  always @(posedge clock) begin
    tdiv <= tdiv + 2'd1;
    tx_bit_tick <= (tdiv == 2'd3);
    if (tx_bit_tick)
      dl_tx_bit <= ~dl_tx_bit;
    cap_en <= tx_bit_tick & dl_suspend_q;
    if (cap_en) begin
      shift <= {tx_bit_q, shift[15:1]};
      nbits <= nbits + 1;
    end
    if (rx_msg_irq_q)
      rx_irqs <= rx_irqs + 1;
    if (tx_msg_irq_q)
      tx_irqs <= tx_irqs + 1;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count = fail_count + 1;
      final_report();
    end
  end
  task automatic final_report;
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", 16'(e), 16'(reg_rdata_q));
  endtask
  task automatic rx_run(input logic [7:0] c, input logic [5:0] cw, input int n, input int e);
    int b;
    b = rx_irqs;
    wr(8'hA0, c);
    far.send(cw, n);
    repeat (4) @(posedge clock);
    chk("rx_irqs", 16'(e), 16'(rx_irqs - b));
  endtask
  task automatic wait_tx;
    int i;
    for (i = 0; i < 100 && tx_irqs == base; i++)
      @(posedge clock);
    chk("tx_irq", 16'd1, 16'(tx_irqs - base));
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 2000 && dl_suspend_q !== 1'b0; i++)
      @(posedge clock);
    repeat (2) @(posedge clock);
  endtask
  task automatic tx_run(input logic [7:0] c, input logic [5:0] cw, input int n);
    base = tx_irqs;
    wr(8'hA0, c);
    wr(8'hA1, {2'b00, cw});
    nbits <= 0;
    wait_tx();
    wait_idle();
    chk("tx_bits", 16'(16 * n), 16'(nbits));
    chk("tx_pat", {1'b0, cw, 1'b0, 8'hFF}, shift);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    // link one taken as reset, disabled and checked idle
    rd(8'hA0, 8'h00);
    rd(8'hA3, 8'h00);
    rd(8'h55, 8'h00);
    rx_run(8'h80, 6'h25, 1, 1);
    rd(8'hA2, 8'h65);
    rd(8'hA2, 8'h25);
    rx_run(8'h80, 6'h0A, 1, 1);
    rx_run(8'h80, 6'h15, 1, 1);
    rd(8'hA2, 8'hD5);
    rx_run(8'h00, 6'h25, 3, 0);
    rx_run(8'hD0, 6'h33, 10, 0);
    rx_run(8'hD0, 6'h33, 2, 1);
    rx_run(8'h90, 6'h11, 9, 0);
    rx_run(8'h90, 6'h22, 1, 0);
    rx_run(8'h90, 6'h11, 9, 0);
    rx_run(8'h90, 6'h11, 1, 1);
    rx_run(8'hB0, 6'h07, 2, 1);
    rx_run(8'hA0, 6'h2A, 24, 0);
    rx_run(8'hA0, 6'h2A, 1, 1);
    tx_run(8'h03, 6'h2D, 1);
    tx_run(8'h07, 6'h12, 10);
    tx_run(8'h0B, 6'h3F, 25);
    base = tx_irqs;
    wr(8'hA0, 8'h00);
    wr(8'hA1, 8'h05);
    repeat (60) @(posedge clock);
    chk("tx_off", 16'd0, 16'(tx_irqs - base));
    prm_pending <= 1'b1;
    dl_buf_empty <= 1'b0;
    wr(8'hA0, 8'h03);
    wr(8'hA1, 8'h05);
    repeat (60) @(posedge clock);
    chk("tx_prm", 16'd0, 16'(tx_irqs - base));
    prm_pending <= 1'b0;
    repeat (60) @(posedge clock);
    chk("tx_buf", 16'd0, 16'(tx_irqs - base));
    dl_buf_empty <= 1'b1;
    wait_tx();
    wait_idle();
    base = tx_irqs;
    dl_buf_empty <= 1'b0;
    dl_out_idle <= 1'b0;
    wr(8'hA0, 8'h0E);
    wr(8'hA1, 8'h09);
    wait_tx();
    repeat (300) @(posedge clock);
    chk("cont", 16'd1, 16'(dl_suspend_q));
    rd(8'hA3, 8'h80);
    rd(8'hA1, 8'h09);
    prm_pending <= 1'b1;
    repeat (80) @(posedge clock);
    chk("yield", 16'd0, 16'(dl_suspend_q));
    prm_pending <= 1'b0;
    wr(8'hA0, 8'h02);
    repeat (4) @(posedge clock);
    wait_idle();
    chk("stop", 16'd0, 16'(dl_suspend_q));
    final_report();
  end
endmodule
`default_nettype wire
